// File: rtl/rucc_cfg.svh
// Offsets, encodings, reset values and sizes for the configuration sequencer
`ifndef RUCC_CFG_SVH
`define RUCC_CFG_SVH

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_WDT_LIMIT   8'h04
`define REG_WDT_CLEAR   8'h08
`define REG_STATUS      8'h0c
`define REG_CRC_REF     8'h10
`define REG_WDT_COUNT   8'h14

// Page that always holds the factory image
`define FACTORY_PAGE    3'h0

// Fallback cause codes held in the status register
`define CAUSE_NONE      3'h0
`define CAUSE_LOAD_FAIL 3'h1
`define CAUSE_CRC       3'h2
`define CAUSE_LENGTH    3'h3
`define CAUSE_WDT       3'h4
`define CAUSE_APP_REQ   3'h5

// Reset values
`define CTRL_RESET      6'h00
`define WDT_LIMIT_RESET 24'hffffff

// Image framing: body bytes, then a four-byte reference value MSB first
`define IMG_BODY_BYTES  6'h20
`define IMG_LAST_BYTE   6'h23
`define SCAN_WRAP       6'h20

// Checksum polynomial and seed
`define CRC_POLY        32'h04c11db7
`define CRC_INIT        32'hffffffff

`endif

// File: rtl/rucc_pkg.sv
// Types shared by the configuration sequencer files
`default_nettype none
package rucc_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_POR,
    ST_GAP,
    ST_LOAD,
    ST_CHECK,
    ST_INIT,
    ST_USER
  } seq_state_t;

  // Pins from the configuration memory or host, all asynchronous
  typedef struct packed {
    logic       chain_enable_in_n;
    logic       remote_mode;
    logic       cfg_strobe;
    logic       cfg_last;
    logic       cfg_fail;
    logic [7:0] cfg_byte;
  } pin_in_t;

  // Control register layout
  typedef struct packed {
    logic       crc_en;
    logic       trig;
    logic       wdt_en;
    logic [2:0] page;
  } ctrl_t;

  // Status register layout
  typedef struct packed {
    logic       wdt_run;
    logic       remote;
    logic       crc_err;
    logic       app_active;
    logic [2:0] page;
    logic [2:0] cause;
  } status_t;

endpackage
`default_nettype wire

// File: rtl/crc32_byte_engine.sv
// Byte-wide 32-bit checksum engine
`include "rucc_cfg.svh"
`default_nettype none
module crc32_byte_engine (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control and data
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  // Running value
  output logic      [31:0] crc
);

  logic [31:0] crc_r;
  logic [31:0] crc_nxt;

  // One byte per clock, MSB first, no reflection and no final inversion
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] v;
    v = c;
    for (int i = 7; i >= 0; i--) begin
      if (v[31] ^ d[i]) begin
        v = {v[30:0], 1'b0} ^ `CRC_POLY;
      end else begin
        v = {v[30:0], 1'b0};
      end
    end
    return v;
  endfunction

  // Clear wins over a byte in the same cycle
  always_comb begin
    crc_nxt = crc_r;
    if (clr) begin
      crc_nxt = `CRC_INIT;
    end else if (en) begin
      crc_nxt = crc_step(crc_r, data);
    end
  end

  // Register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_r <= `CRC_INIT;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;

endmodule
`default_nettype wire

// File: rtl/remote_update_config_ctrl.sv
// Remote/local update configuration sequencer with watchdog and upset check
//
// Functional notes
// - First remote power-up loads the factory image at page zero.
// - Watchdog expiry records its cause in status, then reloads factory image.
// - Watchdog is always off while the factory image is active.
// - Failed application load records its cause, then reloads factory image.
// - Pages one to seven hold applications beside factory page zero.
// - Successful load enters user mode and runs the image.
// - Local mode loads its single image directly, no factory, no selection.
// - Works for serial and parallel sources; async host must offer paging.
// - Devices chain by linking chain enable output to next chain input.
// - User mode checks configuration memory by 32-bit checksum vs bitstream reference.
// - Checksum mismatch raises the configuration error output.
// - User I/O tri-stated until configured; init resets user logic, enables I/O.
`include "rucc_cfg.svh"
`default_nettype none
module remote_update_config_ctrl
  import rucc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Configuration memory or host
  input  wire pin_in_t     cfg_pins,
  output logic             load_req,
  output logic      [2:0]  page_sel,
  // Chain and user side
  output logic             chain_enable_out_n,
  output logic             user_io_oe,
  output logic             user_reset,
  output logic             crc_error,
  // Upset model: flips bit 0 of one stored byte
  input  wire logic        single_event_upset,
  input  wire logic [4:0]  upset_addr
);

  pin_in_t     meta_r;
  pin_in_t     sync_r;
  logic        strobe_d_r;
  logic        strobe_rise;
  seq_state_t  st_r, st_nxt;
  logic [2:0]  page_r, page_nxt;
  logic [2:0]  cause_r, cause_nxt;
  ctrl_t       ctrl_r, ctrl_nxt;
  ctrl_t       ctrl_wr;
  logic [23:0] wdt_limit_r, wdt_limit_nxt;
  logic [23:0] wdt_cnt_r, wdt_cnt_nxt;
  logic        wdt_run_r, wdt_run_nxt;
  logic [5:0]  byte_cnt_r, byte_cnt_nxt;
  logic [31:0] ref_r, ref_nxt;
  logic        remote_r, remote_nxt;
  logic        crc_err_r, crc_err_nxt;
  logic [5:0]  scan_idx_r, scan_idx_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        io_oe_r, chain_n_r, user_rst_r;
  logic [7:0]  img_r [32];
  logic        img_we;
  logic        fail_ev;
  logic [2:0]  fail_code;
  logic        wr_ctrl, wr_limit, wr_clear, wr_status;
  logic        factory, in_user, wdt_exp, scan_wrap;
  logic        crc_clr, crc_en_in;
  logic [7:0]  crc_byte;
  logic [31:0] crc_val;
  status_t     status;

  // Register address match, used for every decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Pin synchronisers; edge detect reads only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r     <= '{chain_enable_in_n: 1'b1, default: '0};
      sync_r     <= '{chain_enable_in_n: 1'b1, default: '0};
      strobe_d_r <= 1'b0;
    end else begin
      meta_r     <= cfg_pins;
      sync_r     <= meta_r;
      strobe_d_r <= sync_r.cfg_strobe;
    end
  end

  // Decodes and conditions shared by the next-state logic
  assign strobe_rise = sync_r.cfg_strobe && !strobe_d_r;
  assign wr_ctrl     = reg_wr && hit(reg_addr, `REG_CTRL);
  assign wr_limit    = reg_wr && hit(reg_addr, `REG_WDT_LIMIT);
  assign wr_clear    = reg_wr && hit(reg_addr, `REG_WDT_CLEAR);
  assign wr_status   = reg_wr && hit(reg_addr, `REG_STATUS);
  assign ctrl_wr     = ctrl_t'(reg_wdata[5:0]);
  assign in_user     = st_r == ST_USER;
  assign factory     = remote_r && page_r == `FACTORY_PAGE;
  assign wdt_exp     = in_user && wdt_run_r && wdt_cnt_r >= wdt_limit_r;
  assign scan_wrap   = in_user && ctrl_r.crc_en && scan_idx_r == `SCAN_WRAP;
  assign img_we      = st_r == ST_LOAD && strobe_rise && byte_cnt_r < `IMG_BODY_BYTES;

  // Checksum source: incoming body bytes while loading, stored bytes in user mode
  assign crc_clr   = st_r == ST_GAP || st_r == ST_INIT || (in_user && !ctrl_r.crc_en) ||
                     scan_wrap;
  assign crc_en_in = img_we || (in_user && ctrl_r.crc_en && scan_idx_r < `SCAN_WRAP);
  assign crc_byte  = in_user ? img_r[scan_idx_r[4:0]] : sync_r.cfg_byte;

  crc32_byte_engine u_crc (
    .clk  (clk),
    .rst  (rst),
    .clr  (crc_clr),
    .en   (crc_en_in),
    .data (crc_byte),
    .crc  (crc_val)
  );

  // Loaded configuration bytes; an upset flips one bit while running
  always_ff @(posedge clk) begin
    if (img_we) begin
      img_r[byte_cnt_r[4:0]] <= sync_r.cfg_byte;
    end else if (single_event_upset && in_user) begin
      img_r[upset_addr] <= img_r[upset_addr] ^ 8'h01;
    end
  end

  // Sequencer, watchdog, status and register next values
  always_comb begin
    st_nxt        = st_r;
    page_nxt      = page_r;
    cause_nxt     = cause_r;
    ctrl_nxt      = ctrl_r;
    wdt_limit_nxt = wdt_limit_r;
    wdt_run_nxt   = wdt_run_r;
    byte_cnt_nxt  = byte_cnt_r;
    ref_nxt       = ref_r;
    remote_nxt    = remote_r;
    crc_err_nxt   = crc_err_r;
    scan_idx_nxt  = 6'h00;
    fail_ev       = 1'b0;
    fail_code     = `CAUSE_NONE;
    // Software clear of the cause; a fallback in the same cycle overrides it
    if (wr_status) begin
      cause_nxt = `CAUSE_NONE;
    end
    // Only the factory image steers page and watchdog choices
    if (wr_ctrl) begin
      ctrl_nxt.crc_en = ctrl_wr.crc_en;
      if (in_user && factory) begin
        ctrl_nxt.page   = ctrl_wr.page;
        ctrl_nxt.wdt_en = ctrl_wr.wdt_en;
      end
    end
    if (wr_limit && in_user && factory) begin
      wdt_limit_nxt = reg_wdata[23:0];
    end
    case (st_r)
      ST_POR: begin
        // Wait for the previous device in the chain to finish
        if (!sync_r.chain_enable_in_n) begin
          remote_nxt = sync_r.remote_mode;
          page_nxt   = `FACTORY_PAGE;
          st_nxt     = ST_GAP;
        end
      end
      ST_GAP: begin
        // Watchdog armed only for an application page in remote mode
        byte_cnt_nxt = 6'h00;
        crc_err_nxt  = 1'b0;
        wdt_run_nxt  = remote_r && ctrl_r.wdt_en && page_r != `FACTORY_PAGE;
        st_nxt       = ST_LOAD;
      end
      ST_LOAD: begin
        // Same byte strobe serves a paged memory or an async parallel host
        if (sync_r.cfg_fail) begin
          fail_ev   = 1'b1;
          fail_code = `CAUSE_LOAD_FAIL;
        end else if (strobe_rise) begin
          byte_cnt_nxt = byte_cnt_r + 6'h01;
          if (byte_cnt_r >= `IMG_BODY_BYTES) begin
            ref_nxt = {ref_r[23:0], sync_r.cfg_byte};
          end
          if (sync_r.cfg_last != (byte_cnt_r == `IMG_LAST_BYTE)) begin
            fail_ev   = 1'b1;
            fail_code = `CAUSE_LENGTH;
          end else if (sync_r.cfg_last) begin
            st_nxt = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        if (crc_val == ref_r) begin
          st_nxt = ST_INIT;
        end else begin
          fail_ev   = 1'b1;
          fail_code = `CAUSE_CRC;
        end
      end
      ST_INIT: begin
        st_nxt = ST_USER;
      end
      ST_USER: begin
        if (wdt_exp) begin
          fail_ev   = 1'b1;
          fail_code = `CAUSE_WDT;
        end else if (wr_ctrl && ctrl_wr.trig) begin
          st_nxt = ST_GAP;
          if (factory) begin
            page_nxt = ctrl_wr.page;
          end else if (remote_r) begin
            page_nxt  = `FACTORY_PAGE;
            cause_nxt = `CAUSE_APP_REQ;
          end
        end
        // Background scan of the stored image
        if (ctrl_r.crc_en && !scan_wrap) begin
          scan_idx_nxt = scan_idx_r + 6'h01;
        end
        if (scan_wrap && crc_val != ref_r) begin
          crc_err_nxt = 1'b1;
        end
      end
      default: begin
        st_nxt = ST_POR;
      end
    endcase
    // Every failure falls back to the factory page with a distinct cause
    if (fail_ev) begin
      cause_nxt = fail_code;
      page_nxt  = `FACTORY_PAGE;
      st_nxt    = ST_GAP;
    end
  end

  // Watchdog counter, cleared by software; runs only in application user mode
  always_comb begin
    wdt_cnt_nxt = 24'h000000;
    if (in_user && wdt_run_r && !wr_clear) begin
      wdt_cnt_nxt = wdt_cnt_r + 24'h000001;
    end
  end

  // Status view and read data, valid only in the cycle after the strobe
  assign status = '{wdt_run: wdt_run_r, remote: remote_r, crc_err: crc_err_r,
                    app_active: in_user && page_r != `FACTORY_PAGE,
                    page: page_r, cause: cause_r};
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_rd) begin
      if (hit(reg_addr, `REG_CTRL)) begin
        rdata_nxt = {26'h0, ctrl_r};
      end else if (hit(reg_addr, `REG_WDT_LIMIT)) begin
        rdata_nxt = {8'h00, wdt_limit_r};
      end else if (hit(reg_addr, `REG_STATUS)) begin
        rdata_nxt = {22'h0, status};
      end else if (hit(reg_addr, `REG_CRC_REF)) begin
        rdata_nxt = ref_r;
      end else if (hit(reg_addr, `REG_WDT_COUNT)) begin
        rdata_nxt = {8'h00, wdt_cnt_r};
      end
    end
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r        <= ST_POR;
      page_r      <= `FACTORY_PAGE;
      cause_r     <= `CAUSE_NONE;
      ctrl_r      <= ctrl_t'(`CTRL_RESET);
      wdt_limit_r <= `WDT_LIMIT_RESET;
      wdt_cnt_r   <= 24'h000000;
      wdt_run_r   <= 1'b0;
      byte_cnt_r  <= 6'h00;
      ref_r       <= 32'h00000000;
      remote_r    <= 1'b0;
      crc_err_r   <= 1'b0;
      scan_idx_r  <= 6'h00;
      rdata_r     <= 32'h00000000;
      io_oe_r     <= 1'b0;
      chain_n_r   <= 1'b1;
      user_rst_r  <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      page_r      <= page_nxt;
      cause_r     <= cause_nxt;
      ctrl_r      <= ctrl_nxt;
      wdt_limit_r <= wdt_limit_nxt;
      wdt_cnt_r   <= wdt_cnt_nxt;
      wdt_run_r   <= wdt_run_nxt;
      byte_cnt_r  <= byte_cnt_nxt;
      ref_r       <= ref_nxt;
      remote_r    <= remote_nxt;
      crc_err_r   <= crc_err_nxt;
      scan_idx_r  <= scan_idx_nxt;
      rdata_r     <= rdata_nxt;
      io_oe_r     <= st_nxt == ST_USER;
      chain_n_r   <= st_nxt != ST_USER;
      user_rst_r  <= st_nxt == ST_INIT;
    end
  end

  // Outputs
  assign load_req           = st_r == ST_LOAD;
  assign page_sel           = page_r;
  assign reg_rdata          = rdata_r;
  assign user_io_oe         = io_oe_r;
  assign chain_enable_out_n = chain_n_r;
  assign user_reset         = user_rst_r;
  assign crc_error          = crc_err_r;

  // Assertions
  property p_first_factory;
    @(posedge clk) disable iff (rst)
      (st_r == ST_POR && st_nxt == ST_GAP) |=> page_sel == 3'h0 ##1 load_req;
  endproperty
  a_first_factory: assert property (p_first_factory) else $error("first load not page 0");

  property p_wdt_off_factory;
    @(posedge clk) disable iff (rst) (in_user && page_r == 3'h0) |-> !wdt_run_r;
  endproperty
  a_wdt_off_factory: assert property (p_wdt_off_factory) else $error("watchdog on in factory");

  property p_wdt_fallback;
    @(posedge clk) disable iff (rst)
      wdt_exp |=> (st_r == ST_GAP && page_sel == 3'h0 && cause_r == 3'h4) ##1 load_req;
  endproperty
  a_wdt_fallback: assert property (p_wdt_fallback) else $error("no watchdog fallback");

  property p_load_fail;
    @(posedge clk) disable iff (rst)
      (st_r == ST_LOAD && sync_r.cfg_fail) |=> st_r == ST_GAP && cause_r == 3'h1 && page_sel == 3'h0;
  endproperty
  a_load_fail: assert property (p_load_fail) else $error("load failure not handled");

  property p_check_fail;
    @(posedge clk) disable iff (rst)
      (st_r == ST_CHECK && crc_val != ref_r) |=> cause_r == 3'h2 && !user_io_oe;
  endproperty
  a_check_fail: assert property (p_check_fail) else $error("bad image accepted");

  property p_init_user;
    @(posedge clk) disable iff (rst)
      st_r == ST_INIT |-> user_reset ##1 (in_user && user_io_oe && !chain_enable_out_n);
  endproperty
  a_init_user: assert property (p_init_user) else $error("init did not enter user mode");

  property p_io_tristate;
    @(posedge clk) disable iff (rst) (st_r != ST_USER) |-> !user_io_oe && chain_enable_out_n;
  endproperty
  a_io_tristate: assert property (p_io_tristate) else $error("I/O enabled before user mode");

  property p_chain_wait;
    @(posedge clk) disable iff (rst)
      (st_r == ST_POR && sync_r.chain_enable_in_n) |=> st_r == ST_POR && !load_req;
  endproperty
  a_chain_wait: assert property (p_chain_wait) else $error("started without chain enable");

  property p_crc_flag;
    @(posedge clk) disable iff (rst) (scan_wrap && crc_val != ref_r) |=> crc_error;
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("mismatch not flagged");

  property p_local_direct;
    @(posedge clk) disable iff (rst) (load_req && !remote_r) |-> page_sel == 3'h0 && !wdt_run_r;
  endproperty
  a_local_direct: assert property (p_local_direct) else $error("local mode selected a page");

  c_wdt_fallback: cover property (@(posedge clk) disable iff (rst) wdt_exp);
  c_app_user: cover property (@(posedge clk) disable iff (rst) status.app_active);
  c_crc_error: cover property (@(posedge clk) disable iff (rst) $rose(crc_error));

endmodule
`default_nettype wire

// File: verif/cfg_memory_model.sv
// Paged configuration memory model that serves byte frames to the sequencer
`include "rucc_cfg.svh"
`default_nettype none
module cfg_memory_model (
  // Clock
  input  wire logic       clk,
  // Sequencer requests
  input  wire logic       load_req,
  input  wire logic [2:0] page_sel,
  // Faults for application pages: 1 fail, 2 bad reference, 3 early last; pacing
  input  wire logic [1:0] mode,
  input  wire logic       slow,
  // Frame pins
  output logic            cfg_strobe,
  output logic            cfg_last,
  output logic            cfg_fail,
  output logic [7:0]      cfg_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  logic gone;
  logic was;

  // Body byte pattern differs per page so a wrong page shows in the checksum
  function automatic logic [7:0] body(input logic [2:0] p, input int i);
    return {p, 5'(i)} ^ 8'h5a;
  endfunction

  // Reference value: MSB-first, no reflection, no final inversion
  function automatic logic [31:0] crc_of(input logic [2:0] p);
    logic [31:0] c;
    c = `CRC_INIT;
    for (int i = 0; i < 32; i++) begin
      c = c ^ {body(p, i), 24'h000000};
      for (int b = 0; b < 8; b++) c = c[31] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // Waits edges, noting a dropped request so an aborted frame stops at once
  task automatic step(input int n);
    for (int k = 0; k < n && !gone; k++) begin
      @(posedge clk);
      #1;
      if (load_req !== 1'b1) gone = 1'b1;
    end
  endtask

  task automatic frame(input logic [2:0] p);
    logic [1:0]  m;
    logic [31:0] r;
    gone = 1'b0;
    m = (p != `FACTORY_PAGE) ? mode : 2'h0; // Factory page is never damaged
    r = (m == 2'h2) ? ~crc_of(p) : crc_of(p);
    for (int i = 0; i < 36 && !gone; i++) begin
      step(1);
      if (!gone) begin
        if (i < 32) cfg_byte <= body(p, i);
        else cfg_byte <= r[8*(35-i) +: 8];
        cfg_last <= (m == 2'h3) ? (i == 34) : (i == 35);
        cfg_fail <= (m == 2'h1) && (i == 5);
      end
      step(3 + 2 * slow);
      if (!gone) cfg_strobe <= 1'b1;
      step(2 + slow);
      cfg_strobe <= 1'b0;
    end
    while (!gone) step(1);
    // Released byte lines show the inverse, not a held value; last and fail drop low
    cfg_byte <= ~cfg_byte;
    cfg_last <= 1'b0;
    cfg_fail <= 1'b0;
  endtask

  // Serve whichever page is selected at each new request
  initial begin
    cfg_strobe = 1'b0;
    cfg_last   = 1'b0;
    cfg_fail   = 1'b0;
    cfg_byte   = 8'h00;
    was        = 1'b0;
    forever begin
      @(posedge clk);
      #1;
      if (load_req === 1'b1 && was === 1'b0) begin
        frame(page_sel);
        was = 1'b0;
      end else was = load_req;
    end
  end
endmodule
`default_nettype wire

// File: verif/remote_update_config_ctrl_bench.sv
// Self-checking bench for the configuration sequencer
`include "rucc_cfg.svh"
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module remote_update_config_ctrl_bench
  import rucc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic [7:0] a; logic [31:0] e;} row_t;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        load_req, chain_enable_out_n, user_io_oe, user_reset, crc_error;
  logic [2:0]  page_sel;
  logic        single_event_upset = 1'b0;
  logic [4:0]  upset_addr = 5'h00;
  logic        chain_enable_in_n = 1'b1;
  logic        remote_mode = 1'b1;
  logic        slow = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic        cfg_strobe, cfg_last, cfg_fail;
  logic [7:0]  cfg_byte;
  pin_in_t     cfg_pins;
  int          fail_count = 0;
  int          total_checks = 0;
  logic        reset_seen = 1'b0;
  logic [31:0] d;
  row_t        rows[7];

  assign cfg_pins = {chain_enable_in_n, remote_mode, cfg_strobe, cfg_last, cfg_fail, cfg_byte};
  always #10 clk = ~clk;

  remote_update_config_ctrl dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cfg_pins(cfg_pins), .load_req(load_req), .page_sel(page_sel),
    .chain_enable_out_n(chain_enable_out_n), .user_io_oe(user_io_oe),
    .user_reset(user_reset), .crc_error(crc_error),
    .single_event_upset(single_event_upset), .upset_addr(upset_addr));
  cfg_memory_model mem (.clk(clk), .load_req(load_req), .page_sel(page_sel), .mode(mode),
    .slow(slow), .cfg_strobe(cfg_strobe), .cfg_last(cfg_last), .cfg_fail(cfg_fail),
    .cfg_byte(cfg_byte));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Register bus cycles: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Bounded wait: 0 load_req, 1 user_io_oe, 2 crc_error
  task automatic wait_until(input int sel, input logic lvl);
    logic s;
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk);
      #1;
      if (user_reset === 1'b1) reset_seen = 1'b1;
      s = (sel == 0) ? load_req : (sel == 1) ? user_io_oe : crc_error;
      if (s === lvl) return;
    end
    fail_count++;
    tally_and_finish();
  endtask

  // Factory image picks the next page and triggers the reload
  task automatic boot(input logic [31:0] ctrl, input logic [2:0] pg);
    wr(`REG_CTRL, ctrl);
    wait_until(0, 1'b1);
    `CHK(page_sel, pg)
    wait_until(1, 1'b1);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1 `CHK({load_req, chain_enable_out_n, user_io_oe, crc_error}, 4'h4)
    @(posedge clk);
    rst <= 1'b0;
    chain_enable_in_n <= 1'b0;
    wait_until(0, 1'b1);
    `CHK(page_sel, `FACTORY_PAGE)
    wait_until(1, 1'b1);
    `CHK({chain_enable_out_n, reset_seen}, 2'h1)
    // Register view of the factory image, unmapped place last
    rows = '{'{`REG_STATUS, 32'h100}, '{`REG_CTRL, 32'h0}, '{`REG_WDT_LIMIT, 32'hffffff},
             '{`REG_WDT_CLEAR, 32'h0}, '{`REG_WDT_COUNT, 32'h0},
             '{`REG_CRC_REF, mem.crc_of(3'h0)}, '{8'h18, 32'h0}};
    foreach (rows[i]) begin
      rd(rows[i].a);
      `CHK(d, rows[i].e)
    end
    // Watchdog: serviced, then left to expire
    wr(`REG_WDT_LIMIT, 32'd300);
    boot(32'h1b, 3'h3);
    rd(`REG_STATUS);
    `CHK(d, 32'h358)
    repeat (3) begin
      repeat (200) @(posedge clk);
      wr(`REG_WDT_CLEAR, 32'h1);
      #1 `CHK(user_io_oe, 1'b1)
    end
    wait_until(0, 1'b1);
    `CHK(page_sel, `FACTORY_PAGE)
    wait_until(1, 1'b1);
    rd(`REG_STATUS);
    `CHK(d, 32'h104)
    wr(`REG_STATUS, 32'h0);
    rd(`REG_STATUS);
    `CHK(d[2:0], `CAUSE_NONE)
    // Failed loads: memory error, bad reference, misplaced last byte
    for (int m = 1; m <= 3; m++) begin
      mode <= 2'(m);
      wr(`REG_CTRL, 32'h10 | (8 - m));
      wait_until(0, 1'b1);
      `CHK(page_sel, 3'(8 - m))
      wait_until(0, 1'b0);
      wait_until(0, 1'b1);
      `CHK(page_sel, `FACTORY_PAGE)
      wait_until(1, 1'b1);
      rd(`REG_STATUS);
      `CHK(d[2:0], 3'(m))
    end
    mode <= 2'h0;
    // Slow memory, then the application asks for the factory image
    slow <= 1'b1;
    boot(32'h12, 3'h2);
    slow <= 1'b0;
    rd(`REG_STATUS);
    `CHK(d[9:3], 7'h2a)
    wr(`REG_CTRL, 32'h10);
    wait_until(0, 1'b1);
    `CHK(page_sel, `FACTORY_PAGE)
    wait_until(1, 1'b1);
    rd(`REG_STATUS);
    `CHK(d[2:0], `CAUSE_APP_REQ)
    // Upset check: quiet while intact, error after one flipped bit
    wr(`REG_CTRL, 32'h20);
    repeat (40) @(posedge clk);
    #1 `CHK(crc_error, 1'b0)
    @(posedge clk);
    single_event_upset <= 1'b1;
    upset_addr <= 5'h05;
    @(posedge clk);
    single_event_upset <= 1'b0;
    wait_until(2, 1'b1);
    rd(`REG_STATUS);
    `CHK(d[7], 1'b1)
    // Local mode after a second reset, held off by the chain input
    rst <= 1'b1;
    chain_enable_in_n <= 1'b1;
    remote_mode <= 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    #1 `CHK(load_req, 1'b0)
    chain_enable_in_n <= 1'b0;
    wait_until(0, 1'b1);
    `CHK(page_sel, 3'h0)
    wait_until(1, 1'b1);
    rd(`REG_STATUS);
    `CHK(d[9:8], 2'h0)
    tally_and_finish();
  end
endmodule
`default_nettype wire
